// ### logic/cnv_i2c_port.sv
`default_nettype none
// Functional notes
// - feedback soft-start first, then accept bus traffic
// - feedback reference fixed, never register writable
// - no traffic means feedback-only operation
// - feedback to register loop applies code immediately
// - register loop slews reference at chosen rate
// - four slave addresses from strap level
// - first byte is address plus direction
// - data stable while clock high
// - start and stop detected on data edges
// - bus busy until free time after stop
// - eight bits then acknowledge slot
// - device acknowledges its own address and every byte after it
// - commit data on falling edge ending LSB
// - reference starts before internal regulator
// - faults block path, then pull down
// - register zero holds loop bit and code
// - control one holds enable, arm, slew, modes
// - control two holds deglitch, soft stop, limit
// - read-only current, voltage, identification bytes
// - read-only status flags, upper bits reserved
// - arm bit clears when voltage command completes
module cnv_i2c_port
  import cnv_pkg::*;
#(
  parameter logic [3:0] VENDOR_ID  = 4'h5, // arbitrary value
  parameter logic [3:0] DIE_ID     = 4'hA, // arbitrary value
  parameter int unsigned FREE_CYC  = BUS_FREE_CYC,
  parameter int unsigned SETTLE_CYC = REF_SETTLE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [1:0]  address_strap_pin,
  input  wire logic        input_supply_ok,
  input  wire logic        internal_supply_ok,
  input  wire logic        thermal_shutdown_flag,
  input  wire logic        thermal_warning_flag,
  input  wire logic        current_fault_flag,
  input  wire logic        power_good_status,
  input  wire logic        overvoltage_latched,
  input  wire logic        overcurrent_latched,
  input  wire logic        soft_start_done,
  input  wire logic [7:0]  current_measure,
  input  wire logic [7:0]  voltage_measure,
  output logic             reference_enable,
  output logic             regulator_enable,
  output logic             signal_path_block,
  output logic             error_amp_pulldown,
  output logic             feedback_path_enable,
  output logic [15:0]      feedback_ref_mv,
  output logic [6:0]       reference_code,
  output logic             slew_busy,
  output logic             switching_enable,
  output logic [2:0]       slew_rate,
  output logic             overvoltage_auto_retry,
  output logic             overcurrent_hiccup_select,
  output logic             light_load_mode,
  output logic [7:0]       system_control_two,
  output logic             bus_busy
);
  typedef struct packed {
    cnv_pwr_e         pwr;
    logic [CNT_W-1:0] pcnt;
    cnv_i2c_e         st;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic [1:0]       byte_idx;
    logic             rw;
    logic [7:0]       ptr;
    logic             sda_drive;
    logic             scl_d;
    logic             sda_d;
    logic             busy;
    logic [CNT_W-1:0] free_cnt;
    logic [7:0]       voltage_select;
    logic [7:0]       ctl1;
    logic [7:0]       ctl2;
    logic             load_now;
    logic             start;
    logic [6:0]       target;
  } cnv_top_s;

  cnv_top_s   r;
  cnv_top_s   next_r;
  logic [1:0] line_q;
  logic       scl;
  logic       sda;
  logic       fault;
  logic       supplies_up;
  logic [6:0] my_addr;
  logic [7:0] rd_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  cnv_slew_if slew_bus ();

  // ==========================================================
  // pin conditioning
  cnv_pin_sync #(.W(2), .IDLE(2'b11)) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .din     ({scl_in, sda_in}),
    .dout    (line_q)
  );

  cnv_ref_slew u_slew (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .sl      (slew_bus.slew)
  );

  assign scl = line_q[1];
  assign sda = line_q[0];

  // edges taken on filtered lines only
  assign scl_rise  = scl & ~r.scl_d;
  assign scl_fall  = ~scl & r.scl_d;
  assign bus_start = scl & r.scl_d & r.sda_d & ~sda;
  assign bus_stop  = scl & r.scl_d & ~r.sda_d & sda;

  assign my_addr     = SLAVE_ADDR_BASE | {4'h0, address_strap_pin, 1'b0};
  assign supplies_up = input_supply_ok & internal_supply_ok;
  assign fault       = ~supplies_up | thermal_shutdown_flag
                     | overvoltage_latched | overcurrent_latched;

  // read mux, unmapped offsets read zero
  always_comb begin
    unique case (r.ptr)
      ADDR_VOLTAGE_SELECT:  rd_data = r.voltage_select;
      ADDR_SYS_CONTROL_ONE: rd_data = r.ctl1;
      ADDR_SYS_CONTROL_TWO: rd_data = r.ctl2;
      ADDR_CURRENT_READ:    rd_data = current_measure;
      ADDR_VOLTAGE_READ:    rd_data = voltage_measure;
      ADDR_CHIP_ID:         rd_data = {VENDOR_ID, DIE_ID};
      ADDR_FAULT_STATUS:    rd_data = {STATUS_RSVD, current_fault_flag, thermal_warning_flag,
                                       thermal_shutdown_flag, power_good_status};
      default:              rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // next state: power sequence, bus engine, registers
  always_comb begin
    next_r          = r;
    next_r.scl_d    = scl;
    next_r.sda_d    = sda;
    next_r.load_now = 1'b0;
    next_r.start    = 1'b0;

    // power sequence
    unique case (r.pwr)
      CNV_P_OFF: begin
        if (!fault) begin
          next_r.pwr  = CNV_P_REF;
          next_r.pcnt = '0;
        end
      end
      CNV_P_REF: begin
        if (fault) begin
          next_r.pwr = CNV_P_BLOCK;
        end else if (r.pcnt >= CNT_W'(SETTLE_CYC - 1)) begin
          next_r.pwr = CNV_P_REG;
        end else begin
          next_r.pcnt = r.pcnt + CNT_W'(1);
        end
      end
      CNV_P_REG: begin
        if (fault) begin
          next_r.pwr = CNV_P_BLOCK;
        end else begin
          next_r.pwr = CNV_P_SOFT;
        end
      end
      CNV_P_SOFT: begin
        if (fault) begin
          next_r.pwr = CNV_P_BLOCK;
        end else if (soft_start_done) begin
          next_r.pwr = CNV_P_RUN;
        end
      end
      CNV_P_RUN: begin
        if (fault) begin
          next_r.pwr = CNV_P_BLOCK;
        end
      end
      CNV_P_BLOCK: begin
        next_r.pwr = CNV_P_PULL;
      end
      CNV_P_PULL: begin
        if (!fault) begin
          next_r.pwr = CNV_P_OFF;
        end
      end
      default: next_r.pwr = CNV_P_OFF;
    endcase

    // bus busy from start until free time after stop
    if (bus_start) begin
      next_r.busy     = 1'b1;
      next_r.free_cnt = '0;
    end else if (r.busy && !r.sda_d && bus_stop) begin
      next_r.free_cnt = CNT_W'(1);
    end else if (r.free_cnt != '0) begin
      if (r.free_cnt >= CNT_W'(FREE_CYC)) begin
        next_r.busy     = 1'b0;
        next_r.free_cnt = '0;
      end else begin
        next_r.free_cnt = r.free_cnt + CNT_W'(1);
      end
    end

    // arm bit clears when slewed command completes
    if (slew_bus.done) begin
      next_r.ctl1[C1_GO_BIT] = 1'b0;
    end

    // byte engine
    if (r.pwr != CNV_P_RUN || bus_stop) begin
      next_r.st        = CNV_I_IDLE;
      next_r.sda_drive = 1'b0;
    end else if (bus_start) begin
      next_r.st        = CNV_I_RX;
      next_r.bitcnt    = '0;
      next_r.byte_idx  = '0;
      next_r.sda_drive = 1'b0;
    end else begin
      unique case (r.st)
        CNV_I_IDLE: begin
          next_r.sda_drive = 1'b0;
        end
        CNV_I_RX: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            next_r.bitcnt = '0;
            next_r.st     = CNV_I_ACK;
            next_r.sda_drive = 1'b1;
            if (r.byte_idx == 2'd0) begin
              next_r.rw = r.shreg[0];
              if (r.shreg[7:1] != my_addr) begin
                next_r.st        = CNV_I_IDLE;
                next_r.sda_drive = 1'b0;
              end
            end else if (r.byte_idx == 2'd1) begin
              next_r.ptr = r.shreg;
            end else begin
              // data byte commit on this falling edge
              unique case (r.ptr)
                ADDR_VOLTAGE_SELECT: begin
                  next_r.voltage_select   = r.shreg;
                  next_r.target = r.shreg[6:0];
                  if (r.voltage_select[VS_LOOP_BIT] && !r.shreg[VS_LOOP_BIT]) begin
                    next_r.load_now = 1'b1;
                  end else if (!r.shreg[VS_LOOP_BIT] && r.ctl1[C1_GO_BIT]) begin
                    next_r.start = 1'b1;
                  end
                end
                ADDR_SYS_CONTROL_ONE: next_r.ctl1 = r.shreg;
                ADDR_SYS_CONTROL_TWO: next_r.ctl2 = r.shreg;
                default: next_r.ctl2 = r.ctl2; // read-only or unmapped ignored
              endcase
            end
            if (r.byte_idx != 2'd3) begin
              next_r.byte_idx = r.byte_idx + 2'd1;
            end
          end
        end
        CNV_I_ACK: begin
          if (scl_fall) begin
            if (r.rw) begin
              next_r.st        = CNV_I_TX;
              next_r.shreg     = rd_data;
              next_r.sda_drive = ~rd_data[7];
            end else begin
              next_r.st        = CNV_I_RX;
              next_r.sda_drive = 1'b0;
            end
          end
        end
        CNV_I_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'h7) begin
              next_r.bitcnt    = '0;
              next_r.sda_drive = 1'b0;
              next_r.st        = CNV_I_MACK;
            end else begin
              next_r.bitcnt    = r.bitcnt + 4'h1;
              next_r.shreg     = {r.shreg[6:0], 1'b0};
              next_r.sda_drive = ~r.shreg[6];
            end
          end
        end
        CNV_I_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              next_r.st = CNV_I_IDLE; // master refused, stop sending
            end else begin
              next_r.bitcnt = 4'h8;
            end
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            next_r.bitcnt    = '0;
            next_r.st        = CNV_I_TX;
            next_r.shreg     = rd_data;
            next_r.sda_drive = ~rd_data[7];
          end
        end
        default: begin
          next_r.st        = CNV_I_IDLE;
          next_r.sda_drive = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // state register, reset acts even with enable low, enable low holds state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r          <= '0;
      r.pwr      <= CNV_P_OFF;
      r.st       <= CNV_I_IDLE;
      r.scl_d    <= 1'b1;
      r.sda_d    <= 1'b1;
      r.voltage_select     <= RST_VOLTAGE_SELECT;
      r.ctl1     <= RST_SYS_CONTROL_ONE;
      r.ctl2     <= RST_SYS_CONTROL_TWO;
      r.target   <= RST_VOLTAGE_SELECT[6:0];
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // slew control and outputs
  assign slew_bus.load_now = r.load_now;
  assign slew_bus.start    = r.start;
  assign slew_bus.target   = r.target;
  assign slew_bus.rate     = r.ctl1[C1_SLEW_HI:C1_SLEW_LO];

  assign sda_out   = 1'b0; // open drain, only ever pulls low
  assign sda_oe    = r.sda_drive;
  assign bus_busy  = r.busy;

  assign reference_enable   = (r.pwr == CNV_P_REF) | (r.pwr == CNV_P_REG)
                            | (r.pwr == CNV_P_SOFT) | (r.pwr == CNV_P_RUN);
  assign regulator_enable   = (r.pwr == CNV_P_REG) | (r.pwr == CNV_P_SOFT)
                            | (r.pwr == CNV_P_RUN);
  assign signal_path_block  = (r.pwr == CNV_P_BLOCK) | (r.pwr == CNV_P_PULL);
  assign error_amp_pulldown = (r.pwr == CNV_P_PULL);

  // feedback reference is a constant, no write path reaches it
  assign feedback_ref_mv      = FB_REF_MV;
  assign feedback_path_enable = r.voltage_select[VS_LOOP_BIT];
  assign reference_code       = slew_bus.code;
  assign slew_busy            = slew_bus.busy;

  assign switching_enable          = r.ctl1[C1_SW_EN_BIT];
  assign slew_rate                 = r.ctl1[C1_SLEW_HI:C1_SLEW_LO];
  assign overvoltage_auto_retry    = r.ctl1[C1_OVP_BIT];
  assign overcurrent_hiccup_select = r.ctl1[C1_OCP_BIT];
  assign light_load_mode           = r.ctl1[C1_MODE_BIT];
  assign system_control_two        = r.ctl2;
endmodule
`default_nettype wire

// ### logic/cnv_pin_sync.sv
`default_nettype none
module cnv_pin_sync #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] IDLE = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cnv_sync_s;

  cnv_sync_s r;
  cnv_sync_s next_r;

  // ==========================================================
  // three stages, output moves only when stages two and three agree
  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s3[i]; // filters single-sample glitches
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= {IDLE, IDLE, IDLE, IDLE};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign dout = r.q;
endmodule
`default_nettype wire

// ### logic/cnv_pkg.sv
`default_nettype none
package cnv_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned BUS_FREE_NS      = 4700;
  localparam int unsigned BUS_FREE_CYC     = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_SETTLE_NS    = 1000;
  localparam int unsigned REF_SETTLE_CYC   = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEW_STEP_NS     = 1000;
  localparam int unsigned SLEW_STEP_CYC    = (SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 10;
  localparam int unsigned SLEW_CNT_W       = 16;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_VOLTAGE_SELECT  = 8'h00;
  localparam logic [7:0] ADDR_SYS_CONTROL_ONE = 8'h01;
  localparam logic [7:0] ADDR_SYS_CONTROL_TWO = 8'h02;
  localparam logic [7:0] ADDR_CURRENT_READ    = 8'h03;
  localparam logic [7:0] ADDR_VOLTAGE_READ    = 8'h04;
  localparam logic [7:0] ADDR_CHIP_ID         = 8'h05;
  localparam logic [7:0] ADDR_FAULT_STATUS    = 8'h06;

  localparam logic [7:0] RST_VOLTAGE_SELECT   = 8'h9E;
  localparam logic [7:0] RST_SYS_CONTROL_ONE  = 8'h80;
  localparam logic [7:0] RST_SYS_CONTROL_TWO  = 8'h00;

  // field positions
  localparam int unsigned VS_LOOP_BIT   = 7;
  localparam int unsigned C1_SW_EN_BIT  = 7;
  localparam int unsigned C1_GO_BIT     = 6;
  localparam int unsigned C1_SLEW_HI    = 5;
  localparam int unsigned C1_SLEW_LO    = 3;
  localparam int unsigned C1_OVP_BIT    = 2;
  localparam int unsigned C1_OCP_BIT    = 1;
  localparam int unsigned C1_MODE_BIT   = 0;

  // slave address base, strap code selects low bits
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h60;
  localparam logic [15:0] FB_REF_MV      = 16'h0258;
  localparam logic [3:0] STATUS_RSVD     = 4'h0;

  typedef enum logic [2:0] {
    CNV_P_OFF   = 3'b000,
    CNV_P_REF   = 3'b001,
    CNV_P_REG   = 3'b011,
    CNV_P_SOFT  = 3'b010,
    CNV_P_RUN   = 3'b110,
    CNV_P_BLOCK = 3'b111,
    CNV_P_PULL  = 3'b101
  } cnv_pwr_e;

  typedef enum logic [2:0] {
    CNV_I_IDLE = 3'b000,
    CNV_I_RX   = 3'b001,
    CNV_I_ACK  = 3'b011,
    CNV_I_TX   = 3'b010,
    CNV_I_MACK = 3'b110
  } cnv_i2c_e;
endpackage
`default_nettype wire

// ### logic/cnv_ref_slew.sv
`default_nettype none
module cnv_ref_slew
  import cnv_pkg::*;
#(
  parameter int unsigned STEP_CYC = SLEW_STEP_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  cnv_slew_if.slew  sl
);
  typedef struct packed {
    logic [6:0]            cur;
    logic [6:0]            tgt;
    logic [SLEW_CNT_W-1:0] cnt;
    logic                  busy;
    logic                  done;
  } cnv_slew_s;

  cnv_slew_s             r;
  cnv_slew_s             next_r;
  logic [SLEW_CNT_W-1:0] period;

  // step period doubles with each rate code
  assign period = SLEW_CNT_W'(STEP_CYC) << sl.rate;

  // ==========================================================
  // reference walks one code per period toward target
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (sl.load_now) begin
      next_r.cur  = sl.target;
      next_r.tgt  = sl.target;
      next_r.busy = 1'b0;
    end else if (sl.start) begin
      next_r.tgt  = sl.target;
      next_r.busy = 1'b1;
      next_r.cnt  = '0;
    end else if (r.busy) begin
      if (r.cur == r.tgt) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else if (r.cnt >= period - SLEW_CNT_W'(1)) begin
        next_r.cnt = '0;
        next_r.cur = (r.cur < r.tgt) ? r.cur + 7'h01 : r.cur - 7'h01;
      end else begin
        next_r.cnt = r.cnt + SLEW_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= {RST_VOLTAGE_SELECT[6:0], RST_VOLTAGE_SELECT[6:0], {SLEW_CNT_W{1'b0}}, 2'b00};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign sl.code = r.cur;
  assign sl.busy = r.busy;
  assign sl.done = r.done;
endmodule
`default_nettype wire

// ### logic/cnv_slew_if.sv
`default_nettype none
interface cnv_slew_if;
  logic       load_now;
  logic       start;
  logic [6:0] target;
  logic [2:0] rate;
  logic [6:0] code;
  logic       busy;
  logic       done;
  modport ctrl (output load_now, output start, output target, output rate,
                input code, input busy, input done);
  modport slew (input load_now, input start, input target, input rate,
                output code, output busy, output done);
endinterface
`default_nettype wire

// ### test/cnv_i2c_master.sv
`default_nettype none
// ==========================================================
// bus master model: data line open drain, only ever pulls low; clock driven high and low
module cnv_i2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime Q = 31.25; // quarter of a 125 ns bit
  // clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: data moves only in the low phase
  task automatic bitx(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // start and repeated start are the same on the wire
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  // stop, then keep the bus free for the idle gap
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #4700;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
                       output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(m, a);
  endtask
endmodule
`default_nettype wire

// ### test/cnv_i2c_port_chk.sv
`default_nettype none
// ==========================================================
// pin-level checks of sequencing and bus timing
module cnv_i2c_port_chk
  import cnv_pkg::*;
#(
  parameter int unsigned FREE_CYC = 8
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_oe,
  input wire logic        reference_enable,
  input wire logic        regulator_enable,
  input wire logic        signal_path_block,
  input wire logic        error_amp_pulldown,
  input wire logic [15:0] feedback_ref_mv,
  input wire logic [6:0]  reference_code,
  input wire logic        slew_busy,
  input wire logic        bus_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // power sequencing
  a_ref_first: assert property ($rose(regulator_enable) |-> $past(reference_enable))
    else $error("regulator on before reference");
  a_block_first: assert property ($rose(error_amp_pulldown) |-> $past(signal_path_block))
    else $error("pulldown before path block");
  a_fb_fixed: assert property (feedback_ref_mv == FB_REF_MV)
    else $error("feedback reference moved");
  a_deaf_early: assert property (!regulator_enable |-> !sda_oe)
    else $error("data line driven before run");
  // ==========================================================
  // bus behaviour
  a_quiet_free: assert property (!bus_busy |-> !sda_oe)
    else $error("data line driven on a free bus");
  a_free_gap: assert property ($fell(bus_busy) |-> $past(scl_in && sda_in, FREE_CYC))
    else $error("bus freed too soon");
  a_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  // slewing holds each code for well over eight cycles
  a_slew_pace: assert property ($changed(reference_code) && slew_busy |=> $stable(reference_code) [*8])
    else $error("reference stepped too fast");
  cover property ($rose(sda_oe));
  cover property ($fell(bus_busy));
  cover property ($rose(slew_busy));
endmodule
bind cnv_i2c_port cnv_i2c_port_chk #(.FREE_CYC(FREE_CYC)) u_chk (.*);
`default_nettype wire

// ### test/converter_i2c_control_port_test.sv
`default_nettype none
module converter_i2c_control_port_test;
  import cnv_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, reset_n, clk_en, scl_in, sda_in, sda_out, sda_oe, m_low;
  logic input_supply_ok, internal_supply_ok, thermal_shutdown_flag, thermal_warning_flag;
  logic current_fault_flag, power_good_status, overvoltage_latched, overcurrent_latched;
  logic soft_start_done, reference_enable, regulator_enable, signal_path_block;
  logic error_amp_pulldown, feedback_path_enable, slew_busy, switching_enable, bus_busy;
  logic overvoltage_auto_retry, overcurrent_hiccup_select, light_load_mode;
  logic [1:0]  address_strap_pin;
  logic [2:0]  slew_rate;
  logic [6:0]  reference_code, dev;
  logic [7:0]  current_measure, voltage_measure, system_control_two;
  logic [15:0] feedback_ref_mv;
  logic [7:0]  exp_q[$], got_q[$];
  string       nm_q[$];
  int          err_count = 0, check_count = 0, seed = 32'h9642f938;
  // ==========================================================
  // harness: wired-and data line with pull-up
  always #4 ref_clk = !ref_clk;
  assign sda_in = !(m_low || sda_oe);
  cnv_i2c_port #(.FREE_CYC(8), .SETTLE_CYC(2), .VENDOR_ID(4'h5), .DIE_ID(4'hA)) dut (.*);
  cnv_i2c_master host (.scl(scl_in), .sda_low(m_low), .sda(sda_in));
  // ==========================================================
  // notes and the watcher that compares them
  task automatic nt(string n, logic [7:0] e, logic [7:0] g);
    nm_q.push_back(n);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  always @(negedge ref_clk) begin
    while (got_q.size() > 0) begin
      check_count++;
      if (got_q[0] !== exp_q[0]) begin
        err_count++;
        $display("wrong value %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
      end
      void'(nm_q.pop_front());
      void'(exp_q.pop_front());
      void'(got_q.pop_front());
    end
  end
  task automatic test_done();
    repeat (2) @(negedge ref_clk);
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // register access: write is address, register, data
  task automatic wr(logic [6:0] a, logic [7:0] r, logic [7:0] d, output logic k);
    logic [7:0] q;
    logic a1, a2, a3;
    host.start();
    host.xbyte({a, 1'b0}, 1'b1, q, a1);
    host.xbyte(r, 1'b1, q, a2);
    host.xbyte(d, 1'b1, q, a3);
    host.stop();
    k = a1 | a2 | a3;
  endtask
  // read through a repeated start, master nacks the byte
  task automatic rd(logic [6:0] a, logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    host.start();
    host.xbyte({a, 1'b0}, 1'b1, q, k);
    host.xbyte(r, 1'b1, q, k);
    host.start();
    host.xbyte({a, 1'b1}, 1'b1, q, k);
    host.xbyte(8'hFF, 1'b1, d, k);
    host.stop();
  endtask
  // watchdog sized well past the full sequence
  initial begin
    #600000;
    err_count++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic k;
    logic [7:0] d, v;
    {clk_en, input_supply_ok, internal_supply_ok, reset_n} = 4'hE;
    {thermal_shutdown_flag, thermal_warning_flag, current_fault_flag} = 3'h0;
    {power_good_status, overvoltage_latched, overcurrent_latched, soft_start_done} = 4'h0;
    {address_strap_pin, current_measure, voltage_measure} = 18'h0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // still soft starting, so the port stays deaf
    wr(7'h60, 8'h02, 8'h5A, k);
    nt("early ack", 8'h01, {7'h0, k});
    @(posedge ref_clk);
    soft_start_done <= 1'b1;
    rd(7'h60, 8'h00, d);
    nt("reg00 reset", 8'h9E, d);
    rd(7'h60, 8'h01, d);
    nt("reg01 reset", RST_SYS_CONTROL_ONE, d);
    rd(7'h60, 8'h02, d);
    nt("reg02 reset", RST_SYS_CONTROL_TWO, d);
    // every strap code answers its own address only
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      address_strap_pin <= 2'(s);
      dev = 7'h60 + 7'(2 * s);
      v = 8'($random(seed));
      wr(dev, 8'h02, v, k);
      nt("own ack", 8'h00, {7'h0, k});
      wr(7'h60 + 7'(2 * ((s + 1) % 4)), 8'h02, ~v, k);
      nt("foreign ack", 8'h01, {7'h0, k});
      nt("reg02 port", v, system_control_two);
      rd(dev, 8'h02, d);
      nt("reg02 read", v, d);
    end
    // read-only bytes follow live inputs, writes ignored
    @(posedge ref_clk);
    current_measure <= 8'($random(seed));
    voltage_measure <= 8'($random(seed));
    {current_fault_flag, thermal_warning_flag, power_good_status} <= 3'($random(seed));
    @(posedge ref_clk);
    wr(dev, 8'h03, ~current_measure, k);
    nt("ro ack", 8'h00, {7'h0, k});
    rd(dev, 8'h03, d);
    nt("current", current_measure, d);
    rd(dev, 8'h04, d);
    nt("voltage", voltage_measure, d);
    rd(dev, 8'h05, d);
    nt("ident", 8'h5A, d);
    rd(dev, 8'h06, d);
    nt("status", {4'h0, current_fault_flag, thermal_warning_flag, 1'b0, power_good_status}, d);
    rd(dev, 8'h07, d);
    nt("unmapped", 8'h00, d);
    // control one fields reach their outputs
    v = 8'($random(seed)) & 8'hBF;
    wr(dev, 8'h01, v, k);
    nt("reg01 port", v, {switching_enable, 1'b0, slew_rate, overvoltage_auto_retry,
                         overcurrent_hiccup_select, light_load_mode});
    // loop change applies the code at once
    wr(dev, 8'h00, 8'h85, k);
    wr(dev, 8'h00, 8'h05, k);
    nt("loop switch", 8'h05, {feedback_path_enable, reference_code});
    // armed change at rate 3 takes 1000 cycles per code
    wr(dev, 8'h01, 8'hD8, k);
    wr(dev, 8'h00, 8'h07, k);
    nt("slewing", 8'h85, {slew_busy, reference_code});
    repeat (2200) @(posedge ref_clk);
    nt("slew end", 8'h07, {slew_busy, reference_code});
    rd(dev, 8'h01, d);
    nt("arm cleared", 8'h98, d);
    // fault: block the path, then pull down
    @(posedge ref_clk);
    thermal_shutdown_flag <= 1'b1;
    repeat (6) @(posedge ref_clk);
    nt("pulled down", 8'h03, {6'h0, signal_path_block, error_amp_pulldown});
    test_done();
  end
endmodule
`default_nettype wire
